/* File: logic/crb_ctrl.sv */
`timescale 1ns/1ns

// Notes on behaviour
// - transmit error tally is an 8-bit read-only register, zero after reset.
// - tally overflow enters bus-off; node then ignores bus traffic.
// - tally clears after 128 runs of 11 recessive bits.
// - receive-full flag (bit 7) sets when a message lands in buffer 0.
// - buffer 0 takes a new message only while full flag is zero.
// - mode 11 accepts every message, erroneous ones included.
// - mode 10 accepts only error-free extended-identifier messages.
// - mode 01 accepts only error-free standard-identifier messages.
// - mode 00 accepts all error-free messages; it is the reset mode.
// - bit 4 of the buffer 0 control register reads zero.
// - bit 3 shows whether the held message is a remote request.
// - bit 0 records which acceptance filter admitted the held message.
module crb_ctrl
    import crb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CRB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic can_rx,
    input wire logic bit_tick,
    input wire logic tx_err,
    input wire logic tx_ok,
    input wire logic msg_valid,
    input wire logic msg_ext,
    input wire logic msg_rtr,
    input wire logic msg_err,
    input wire logic msg_filter,
    output logic bus_off,
    output logic rxb0_store,
    output logic rxb1_store,
    output logic rxb0_full
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic addr_hit(
        input logic [CRB_ADR_W-1:0] adr,
        input logic [3:0] ofs
    );
        addr_hit = (adr == ofs);
    endfunction

    function automatic logic mode_accepts(
        input logic [1:0] mode,
        input logic ext,
        input logic err
    );
        case (mode)
            CRB_MODE_ANY: mode_accepts = 1'b1;
            CRB_MODE_EXT: mode_accepts = !err && ext;
            CRB_MODE_STD: mode_accepts = !err && !ext;
            CRB_MODE_VALID: mode_accepts = !err;
            default: mode_accepts = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    crb_state_e state_reg;
    crb_state_e state_next;
    logic bus_off_reg;
    logic bus_off_next;
    logic [7:0] tally_reg;
    logic [7:0] tally_next;
    logic full_reg;
    logic full_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic rtr_reg;
    logic rtr_next;
    logic dben_reg;
    logic dben_next;
    logic fhit_reg;
    logic fhit_next;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic store0_reg;
    logic store1_reg;
    logic rx_meta_reg;
    logic rx_sync_reg;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // bus-off recovery: recessive runs only count while off
    // ------------------------------------------------------------
    logic in_busoff;
    logic recovered;

    assign in_busoff = (state_reg == CRB_BUSOFF);

    crb_recess_cnt u_recess (
        .clk(clk),
        .rst(rst),
        .enable(in_busoff),
        .bit_tick(bit_tick),
        .rx_recessive(rx_sync_reg),
        .done(recovered)
    );

    // ------------------------------------------------------------
    // transmit error tally
    // ------------------------------------------------------------
    logic [8:0] tally_up;
    logic [8:0] tally_sum;
    logic tally_ovf;

    assign tally_up = {1'b0, tally_reg}
        + (tx_err ? CRB_TEC_ERR_STEP : 9'h000);
    // a success never takes the tally below zero
    assign tally_sum = (tx_ok && tally_up != 9'h000)
        ? tally_up - CRB_TEC_OK_STEP : tally_up;
    assign tally_ovf = !in_busoff && (tally_sum > CRB_TEC_MAX);

    always_comb begin
        state_next = state_reg;
        tally_next = tally_reg;
        case (state_reg)
            CRB_ACTIVE: begin
                if (tally_ovf) begin
                    state_next = CRB_BUSOFF;
                    tally_next = CRB_TEC_MAX[7:0];
                end else begin
                    tally_next = tally_sum[7:0];
                end
            end
            CRB_BUSOFF: begin
                // no transmit events count while off the bus
                if (recovered) begin
                    state_next = CRB_ACTIVE;
                    tally_next = CRB_TALLY_RST;
                end
            end
            default: begin
                state_next = CRB_ACTIVE;
                tally_next = CRB_TALLY_RST;
            end
        endcase
    end

    // ------------------------------------------------------------
    // acceptance and buffer steering
    // ------------------------------------------------------------
    logic accept;
    logic to_b0;
    logic to_b1;

    // a node that is off the bus takes no part in reception
    assign accept = msg_valid && !in_busoff
        && mode_accepts(mode_reg, msg_ext, msg_err);
    assign to_b0 = accept && !full_reg;
    assign to_b1 = accept && full_reg && dben_reg;

    // ------------------------------------------------------------
    // wishbone slave: one wait state, then ack for one cycle
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic hit_tally;
    logic hit_rxb0;
    logic wr_rxb0;
    logic clr_full;
    logic [7:0] rxb0_view;

    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;
    assign hit_tally = addr_hit(wb_adr_i, CRB_OFS_TALLY);
    assign hit_rxb0 = addr_hit(wb_adr_i, CRB_OFS_RXB0);
    assign wr_rxb0 = wr && hit_rxb0 && wb_sel_i[0];
    // only a zero written to the full bit has an effect
    assign clr_full = wr_rxb0 && !wb_dat_i[CRB_B_FULL];

    always_comb begin
        rxb0_view = 8'h00;
        rxb0_view[CRB_B_FULL] = full_reg;
        rxb0_view[CRB_B_MODE_HI] = mode_reg[1];
        rxb0_view[CRB_B_MODE_LO] = mode_reg[0];
        rxb0_view[CRB_B_UNUSED] = 1'b0;
        rxb0_view[CRB_B_RTR] = rtr_reg;
        rxb0_view[CRB_B_DBEN] = dben_reg;
        rxb0_view[CRB_B_JUMP_TABLE_OFFSET] = dben_reg;
        rxb0_view[CRB_B_FHIT] = fhit_reg;
    end

    assign dat_next = !(req && !wb_we_i) ? 32'h00000000 :
        hit_tally ? {24'h000000, tally_reg} :
        hit_rxb0 ? {24'h000000, rxb0_view} : 32'h00000000;

    // ------------------------------------------------------------
    // receive buffer 0 control fields
    // ------------------------------------------------------------
    // a store in the same cycle as a clear wins
    assign full_next = to_b0 ? 1'b1 : (clr_full ? 1'b0 : full_reg);
    assign mode_next = wr_rxb0
        ? wb_dat_i[CRB_B_MODE_HI:CRB_B_MODE_LO] : mode_reg;
    assign dben_next = wr_rxb0 ? wb_dat_i[CRB_B_DBEN] : dben_reg;
    assign rtr_next = to_b0 ? msg_rtr : rtr_reg;
    assign fhit_next = to_b0 ? msg_filter : fhit_reg;

    // ------------------------------------------------------------
    // error state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= CRB_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tally_reg <= CRB_TALLY_RST;
        end else begin
            tally_reg <= tally_next;
        end
    end

    // a flag of its own, so the pin never hangs off a compare
    assign bus_off_next = (state_next == CRB_BUSOFF);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_off_reg <= 1'h0;
        end else begin
            bus_off_reg <= bus_off_next;
        end
    end

    // ------------------------------------------------------------
    // buffer 0 control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            full_reg <= CRB_BIT_RST;
        end else begin
            full_reg <= full_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= CRB_MODE_RST;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rtr_reg <= CRB_BIT_RST;
        end else begin
            rtr_reg <= rtr_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dben_reg <= CRB_BIT_RST;
        end else begin
            dben_reg <= dben_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fhit_reg <= CRB_BIT_RST;
        end else begin
            fhit_reg <= fhit_next;
        end
    end

    // ------------------------------------------------------------
    // bus answer and store pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'h0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_reg <= 32'h00000000;
        end else begin
            dat_reg <= dat_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store0_reg <= 1'h0;
        end else begin
            store0_reg <= to_b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store1_reg <= 1'h0;
        end else begin
            store1_reg <= to_b1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign bus_off = bus_off_reg;
    assign rxb0_store = store0_reg;
    assign rxb1_store = store1_reg;
    assign rxb0_full = full_reg;

endmodule

/* File: logic/crb_pkg.sv */
package crb_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int unsigned CRB_ADR_W = 4;
    localparam logic [3:0] CRB_OFS_TALLY = 4'h0;
    localparam logic [3:0] CRB_OFS_RXB0 = 4'h4;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] CRB_TALLY_RST = 8'h00;
    localparam logic [1:0] CRB_MODE_RST = 2'h0;
    localparam logic CRB_BIT_RST = 1'b0;

    // ------------------------------------------------------------
    // receive buffer 0 control field positions
    // ------------------------------------------------------------
    localparam int unsigned CRB_B_FULL = 7;
    localparam int unsigned CRB_B_MODE_HI = 6;
    localparam int unsigned CRB_B_MODE_LO = 5;
    localparam int unsigned CRB_B_UNUSED = 4;
    localparam int unsigned CRB_B_RTR = 3;
    localparam int unsigned CRB_B_DBEN = 2;
    localparam int unsigned CRB_B_JUMP_TABLE_OFFSET = 1;
    localparam int unsigned CRB_B_FHIT = 0;

    // ------------------------------------------------------------
    // receive mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] CRB_MODE_VALID = 2'h0;
    localparam logic [1:0] CRB_MODE_STD = 2'h1;
    localparam logic [1:0] CRB_MODE_EXT = 2'h2;
    localparam logic [1:0] CRB_MODE_ANY = 2'h3;

    // ------------------------------------------------------------
    // error tally steps and bus-off recovery counts
    // ------------------------------------------------------------
    localparam logic [8:0] CRB_TEC_ERR_STEP = 9'h008;
    localparam logic [8:0] CRB_TEC_OK_STEP = 9'h001;
    localparam logic [8:0] CRB_TEC_MAX = 9'h0FF;
    localparam logic [3:0] CRB_RUN_BITS = 4'hB;
    localparam logic [7:0] CRB_RUN_COUNT = 8'h80;

    typedef enum logic {
        CRB_ACTIVE,
        CRB_BUSOFF
    } crb_state_e;

endpackage

/* File: logic/crb_recess_cnt.sv */
`timescale 1ns/1ns
module crb_recess_cnt
    import crb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic bit_tick,
    input wire logic rx_recessive,
    output logic done
);

    // ------------------------------------------------------------
    // run and occurrence counters
    // ------------------------------------------------------------
    logic [3:0] run_reg;
    logic [3:0] run_next;
    logic [7:0] occ_reg;
    logic [7:0] occ_next;
    logic done_reg;
    logic done_next;
    logic run_end;
    logic [7:0] occ_inc;

    assign run_end = bit_tick && rx_recessive
        && (run_reg == CRB_RUN_BITS - 4'h1);
    assign occ_inc = occ_reg + 8'h01;

    // a dominant bit restarts the run; a full run starts the next one
    assign run_next = !enable ? 4'h0 :
        !bit_tick ? run_reg :
        !rx_recessive ? 4'h0 :
        run_end ? 4'h0 : run_reg + 4'h1;
    assign occ_next = !enable ? 8'h00 :
        !run_end ? occ_reg :
        (occ_inc == CRB_RUN_COUNT) ? 8'h00 : occ_inc;
    assign done_next = enable && run_end && (occ_inc == CRB_RUN_COUNT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_reg <= 4'h0;
            occ_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
            occ_reg <= occ_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

endmodule

/* File: bench/crb_ctrl_chk.sv */
`timescale 1ns/1ns
module crb_ctrl_chk
    import crb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CRB_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic msg_valid,
    input wire logic bus_off,
    input wire logic rxb0_store,
    input wire logic rxb1_store,
    input wire logic rxb0_full
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data not zero");
    chk_ctrl_fixed: assert property (wb_ack_o && !$past(wb_we_i) &&
        $past(wb_adr_i) == CRB_OFS_RXB0 |-> wb_dat_o[4] == 1'h0 &&
        wb_dat_o[1] == wb_dat_o[2]) else $error("ctrl fixed bits");
    chk_tally_sat: assert property (wb_ack_o && bus_off
        && $past(bus_off) && $past(wb_adr_i) == CRB_OFS_TALLY
        && !$past(wb_we_i)
        |-> wb_dat_o[7:0] == 8'hFF) else $error("tally not saturated");
    chk_store_cause: assert property (rxb0_store || rxb1_store |->
        $past(msg_valid) && !$past(bus_off)) else $error("store uncaused");
    chk_store_full: assert property (rxb0_store |-> rxb0_full &&
        !$past(rxb0_full) && !rxb1_store) else $error("store0 wrong");
    chk_redirect_full: assert property (
        rxb1_store |-> $past(rxb0_full)) else $error("store1 without full");
    chk_offline_quiet: assert property ($past(bus_off) && bus_off |->
        !rxb0_store && !rxb1_store) else $error("store in bus-off");
endmodule

bind crb_ctrl crb_ctrl_chk u_chk (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .msg_valid(msg_valid), .bus_off(bus_off),
    .rxb0_store(rxb0_store), .rxb1_store(rxb1_store),
    .rxb0_full(rxb0_full)
);

/* File: bench/crb_bus_node.sv */
`timescale 1ns/1ns
module crb_bus_node (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    output logic bit_tick,
    output logic can_rx
);
    logic [1:0] phase_reg;
    logic [3:0] ticks_reg;
    // idle bus rests recessive; one dominant bit in the sixth bit time
    // breaks the first run, so recovery has to start counting afresh
    assign can_rx = (ticks_reg != 4'h5);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= 2'h0;
            bit_tick <= 1'h0;
            ticks_reg <= 4'h0;
        end else begin
            phase_reg <= en ? phase_reg + 2'h1 : 2'h0;
            bit_tick <= en && phase_reg == 2'h3;
            ticks_reg <= !en ? 4'h0 :
                (bit_tick && ticks_reg != 4'hF) ? ticks_reg + 4'h1 :
                ticks_reg;
        end
    end
endmodule

/* File: bench/can_rx_buffer0_ctrl_tx_errcnt_bench.sv */
`timescale 1ns/1ns
module can_rx_buffer0_ctrl_tx_errcnt_bench;
    import crb_pkg::*;
    logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [CRB_ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic wb_ack_o, can_rx, bit_tick, tx_err = 0, tx_ok = 0, node_en = 0;
    logic msg_valid = 0, msg_ext = 0, msg_rtr = 0, msg_err = 0;
    logic msg_filter = 0, bus_off, rxb0_store, rxb1_store, rxb0_full, s0, s1;
    logic [7:0] q;
    int miscompares = 0, tests_run = 0;
    always #20 clk = ~clk;
    crb_ctrl dut (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .can_rx(can_rx), .bit_tick(bit_tick), .tx_err(tx_err),
        .tx_ok(tx_ok), .msg_valid(msg_valid), .msg_ext(msg_ext),
        .msg_rtr(msg_rtr), .msg_err(msg_err), .msg_filter(msg_filter),
        .bus_off(bus_off), .rxb0_store(rxb0_store),
        .rxb1_store(rxb1_store), .rxb0_full(rxb0_full)
    );
    crb_bus_node node (
        .clk(clk), .rst(rst), .en(node_en), .bit_tick(bit_tick),
        .can_rx(can_rx)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task check(input string n, input logic [7:0] seen, input logic [7:0] e);
        tests_run++;
        if (seen !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, seen);
        end
    endtask
    task wb(input logic we, input logic [3:0] a, input logic [7:0] d,
            input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        if (n >= 20) check("ack", 8'h0, 8'h1);
    endtask
    task msg(input logic e, input logic r, input logic er, input logic f);
        @(posedge clk);
        msg_valid <= 1'h1;
        msg_ext <= e;
        msg_rtr <= r;
        msg_err <= er;
        msg_filter <= f;
        @(posedge clk);
        msg_valid <= 1'h0;
        @(posedge clk);
        s0 = rxb0_store;
        s1 = rxb1_store;
    endtask
    task pulse(input logic err, input int k);
        repeat (k) begin
            @(posedge clk);
            tx_err <= err;
            tx_ok <= !err;
            @(posedge clk);
            tx_err <= 1'h0;
            tx_ok <= 1'h0;
        end
    endtask
    task report_and_stop;
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, CRB_TALLY_RST);
        wb(1, CRB_OFS_TALLY, 8'h55, 4'hF);
        wb(1, CRB_OFS_RXB0, 8'h64, 4'hE);
        wb(0, CRB_OFS_RXB0, 8'h0, 4'hF);
        check("ctrl", q, 8'h00);
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, 8'h00);
        wb(0, 4'h8, 8'h0, 4'hF);
        check("unmapped", q, 8'h00);
    endtask
    task t_modes;
        logic acc, lr, lf;
        logic [7:0] exp_v;
        lr = 1'h0;
        lf = 1'h0;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                wb(1, CRB_OFS_RXB0, {1'h0, m[1:0], 5'h0}, 4'hF);
                msg(k[0], k[0], k[1], !k[0]);
                acc = m == 3 || (!k[1] && (m == 0 || m == 1 + k[0]));
                if (acc) {lr, lf} = {k[0], !k[0]};
                exp_v = {7'h0, acc};
                check("store0", {7'h0, s0}, exp_v);
                wb(0, CRB_OFS_RXB0, 8'h0, 4'hF);
                exp_v = {acc, m[1:0], 1'h0, lr, 2'h0, lf};
                check("ctrl", q, exp_v);
            end
        end
    endtask
    task t_full;
        wb(1, CRB_OFS_RXB0, 8'h00, 4'hF);
        msg(0, 1, 0, 1);
        wb(1, CRB_OFS_RXB0, 8'h80, 4'hF);
        check("full", {7'h0, rxb0_full}, 8'h1);
        msg(0, 0, 0, 0);
        check("stores", {6'h0, s1, s0}, 8'h0);
        wb(1, CRB_OFS_RXB0, 8'h94, 4'hF);
        wb(0, CRB_OFS_RXB0, 8'h0, 4'hF);
        check("ctrl", q, 8'h8F);
        msg(0, 0, 0, 0);
        check("stores", {6'h0, s1, s0}, 8'h2);
        wb(1, CRB_OFS_RXB0, 8'h00, 4'hF);
        check("full", {7'h0, rxb0_full}, 8'h0);
    endtask
    task t_tally;
        int n;
        // a success at zero must leave the tally at zero
        pulse(0, 1);
        pulse(1, 2);
        pulse(0, 1);
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, 8'h0F);
        // 15 + 30 * 8 lands exactly on the top value
        pulse(1, 30);
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, 8'hFF);
        check("bus_off", {7'h0, bus_off}, 8'h0);
        pulse(1, 1);
        // the flag is launched at the edge the task returns on
        @(posedge clk);
        check("bus_off", {7'h0, bus_off}, 8'h1);
        msg(0, 0, 0, 0);
        check("stores", {6'h0, s1, s0}, 8'h0);
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, 8'hFF);
        @(posedge clk);
        node_en <= 1'h1;
        n = 0;
        while (bus_off !== 1'h0 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        node_en <= 1'h0;
        // a dominant sixth bit breaks the first run, then 128 runs of
        // 11 ticks follow, one tick every 4 cycles
        check("recovery", {7'h0, n >= 5657 && n <= 5661}, 8'h1);
        wb(0, CRB_OFS_TALLY, 8'h0, 4'hF);
        check("tally", q, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_modes;
        t_full;
        t_tally;
        report_and_stop;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        report_and_stop;
    end
endmodule
